// ===== include/kfc_map.svh
// Constants of the keypad and fan command handler: command codes, lengths,
// key bit positions, fan channel counts, reset values and timing counts.
// Assumes a 50 MHz clock; included by the fan channel and command handler modules.
`ifndef KFC_MAP_SVH
`define KFC_MAP_SVH

// Command codes and reply type flags
`define KFC_CMD_LCD 8'h16
`define KFC_CMD_KEYCFG 8'h17
`define KFC_CMD_POLL 8'h18
`define KFC_CMD_FAILSAFE 8'h19
`define KFC_CMD_GLITCH 8'h1a
`define KFC_REPLY_FLAG 8'h40
`define KFC_ERROR_FLAG 8'h80

// Payload and reply lengths in bytes
`define KFC_LEN_KEYCFG 8'h02
`define KFC_LEN_POLL 8'h00
`define KFC_LEN_FAILSAFE 8'h02
`define KFC_LEN_GLITCH 8'h04
`define KFC_LEN_POLL_REPLY 8'h03
`define KFC_LEN_ACK 8'h00

// Key bit positions inside every key mask
`define KFC_KEY_UP_POS 0
`define KFC_KEY_ACCEPT_POS 1
`define KFC_KEY_ABORT_POS 2
`define KFC_KEY_LEFT_POS 3
`define KFC_KEY_RIGHT_POS 4
`define KFC_KEY_DOWN_POS 5

// Fan channels in payloads, and how many are wired on this variant
`define KFC_FAN_CHANNELS 4
`define KFC_FAN_DRIVEN 3
`define KFC_FAN_MASK_MAX 8'h0f

// Reset values and the full-power fan setting
`define KFC_KEY_MASK_RST 8'h3f
`define KFC_GLITCH_RST 8'h01
`define KFC_FAN_FULL_POWER 8'h64

// Timing: clock, fail-safe tick and glitch count
`define KFC_CLK_PERIOD_NS 20
`define KFC_FS_TICK_NS 125000000
`define KFC_FS_TICK_CYC (`KFC_FS_TICK_NS / `KFC_CLK_PERIOD_NS)
`define KFC_GLITCH_NS 552500
`define KFC_GLITCH_CYC (`KFC_GLITCH_NS / `KFC_CLK_PERIOD_NS)
`define KFC_PWM_HZ 18
`define KFC_PWM_STEPS 7'h64

`endif

// ===== include/kfc_pkg.sv
// Types shared by the keypad and fan command handler modules.
// Numeric constants live in kfc_map.svh.
package kfc_pkg;

    typedef logic [7:0] kfc_byte_type;

    typedef enum logic [1:0] {
        KFC_ST_IDLE,
        KFC_ST_BODY,
        KFC_ST_EXEC
    } kfc_state_type;

endpackage

// ===== logic/kfc_key_tracker.sv
// Keypad tracker: synchronises the key pins, finds press and release edges
// and keeps the pressed-since and released-since masks between polls.
// Assumes key pins low while held, already debounced outside.
`timescale 1ns/1ns
module kfc_key_tracker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Keypad pins, low while held
    input wire logic [5:0] key_n,
    // Poll restarts both accumulators
    input wire logic poll_clear,
    // Key state
    output logic [5:0] held_q,
    output logic [5:0] pressed_q,
    output logic [5:0] released_q,
    output logic [5:0] rise_q,
    output logic [5:0] fall_q
);
    logic [5:0] meta_q;
    logic [5:0] prev_q;
    logic [5:0] rise_w;
    logic [5:0] fall_w;
    logic [5:0] pressed_d;
    logic [5:0] released_d;

    assign rise_w = held_q & ~prev_q;
    assign fall_w = ~held_q & prev_q;
    // A new edge in the poll cycle lands in the fresh accumulator
    assign pressed_d = (poll_clear ? 6'h00 : pressed_q) | rise_w;
    assign released_d = (poll_clear ? 6'h00 : released_q) | fall_w;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            meta_q <= 6'h00;
            held_q <= 6'h00;
            prev_q <= 6'h00;
            pressed_q <= 6'h00;
            released_q <= 6'h00;
            rise_q <= 6'h00;
            fall_q <= 6'h00;
        end
        else
        begin
            meta_q <= ~key_n;
            held_q <= meta_q;
            prev_q <= held_q;
            pressed_q <= pressed_d;
            released_q <= released_d;
            rise_q <= rise_w;
            fall_q <= fall_w;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_poll_restart: assert property (poll_clear |=> pressed_q == $past(rise_w))
        else $error("pressed mask not restarted by poll");
    a_release_keep: assert property (!poll_clear && fall_w != 6'h00
        |=> (released_q & $past(fall_w)) == $past(fall_w))
        else $error("release edge lost");

endmodule // kfc_key_tracker

// ===== logic/kfc_fan_channel.sv
// One fan channel: PWM output from the shared phase, forced on by the
// fail-safe, and tachometer edges blanked after each power-on.
// Assumes phase and step come from the shared 100-step PWM divider.
`timescale 1ns/1ns
`include "kfc_map.svh"
module kfc_fan_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Shared PWM timebase
    input wire logic step,
    input wire logic [6:0] phase,
    // Channel settings
    input wire logic [7:0] power,
    input wire logic force_full,
    input wire logic [7:0] delay,
    // Tachometer pin
    input wire logic tach,
    // Outputs
    output logic pwm_q,
    output logic tach_edge_q
);
    logic [7:0] blank_q;
    logic [2:0] tach_q;
    logic on_w;
    logic turn_on_w;
    logic edge_w;

    assign on_w = force_full || power >= `KFC_FAN_FULL_POWER || {1'b0, phase} < power;
    assign turn_on_w = on_w && !pwm_q;
    assign edge_w = tach_q[1] ^ tach_q[2];

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pwm_q <= 1'b0;
            blank_q <= 8'h00;
            tach_q <= 3'h0;
            tach_edge_q <= 1'b0;
        end
        else
        begin
            pwm_q <= on_w;
            tach_q <= {tach_q[1:0], tach};
            if (turn_on_w)
                blank_q <= delay;
            else if (step && blank_q != 8'h00)
                blank_q <= blank_q - 8'h01;
            tach_edge_q <= edge_w && pwm_q && blank_q == 8'h00;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_tach_blanked: assert property (blank_q != 8'h00 |=> !tach_edge_q)
        else $error("tach edge passed during glitch delay");
    a_force_full: assert property (force_full |=> pwm_q)
        else $error("fail-safe fan not at full power");
    a_blank_load: assert property (turn_on_w |=> blank_q == $past(delay))
        else $error("glitch delay not loaded at power-on");

endmodule // kfc_fan_channel

// ===== logic/kfc_cmd_handler.sv
// Keypad and fan command handler: parses host packets, forwards display
// commands, keeps key reporting masks, answers keypad polls, runs the fan
// fail-safe timer and the fan PWM with tachometer glitch blanking.
// Assumes framed packets from a link layer (CRC already checked) and a
// separate store that keeps the boot-state outputs across power cycles.
`timescale 1ns/1ns
`include "kfc_map.svh"
module kfc_cmd_handler #(
    parameter int unsigned FS_TICK_CYCLES = `KFC_FS_TICK_CYC,
    parameter int unsigned GLITCH_CYCLES = `KFC_GLITCH_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Received packet bytes: type first, then payload
    input wire logic rx_valid,
    input wire logic rx_sop,
    input wire logic rx_eop,
    input wire logic [7:0] rx_data,
    // Reply packet
    output logic tx_valid_q,
    output logic [7:0] tx_type_q,
    output logic [7:0] tx_len_q,
    output logic [7:0] tx_d0_q,
    output logic [7:0] tx_d1_q,
    output logic [7:0] tx_d2_q,
    // Display controller byte stream
    output logic lcd_valid_q,
    output logic [7:0] lcd_data_q,
    // Keypad pins and key event reports
    input wire logic [5:0] key_n,
    output logic [5:0] evt_press_q,
    output logic [5:0] evt_release_q,
    // Fan power from the power command, and its rewrite strobe
    input wire logic [7:0] fan1_power,
    input wire logic [7:0] fan2_power,
    input wire logic [7:0] fan3_power,
    input wire logic fan_power_write,
    // Fan pins
    input wire logic [2:0] fan_tach,
    output logic [2:0] fan_pwm_q,
    output logic [2:0] tach_edge_q,
    // Fail-safe state
    output logic [3:0] fs_mask_q,
    output logic fs_tripped_q,
    // Boot-state capture
    input wire logic store_boot,
    output logic [7:0] boot_press_mask_q,
    output logic [7:0] boot_release_mask_q,
    output logic [31:0] boot_glitch_q
);
    kfc_pkg::kfc_state_type state_q;
    kfc_pkg::kfc_state_type state_d;
    kfc_pkg::kfc_byte_type cmd_q;
    kfc_pkg::kfc_byte_type len_q;
    kfc_pkg::kfc_byte_type buf_q [4];
    kfc_pkg::kfc_byte_type glitch_q [4];
    logic [7:0] press_mask_q;
    logic [7:0] release_mask_q;
    logic [7:0] fs_timeout_q;
    logic [7:0] fs_count_q;
    logic [22:0] fs_div_q;
    logic [14:0] step_div_q;
    logic [6:0] phase_q;
    logic [5:0] held_w;
    logic [5:0] pressed_w;
    logic [5:0] released_w;
    logic [5:0] rise_w;
    logic [5:0] fall_w;
    logic [7:0] power_w [3];
    logic [31:0] glitch_pack_w;

    // Packet parsing
    wire start_w = rx_valid && rx_sop;
    wire body_byte_w = rx_valid && !rx_sop && state_q == kfc_pkg::KFC_ST_BODY;
    wire exec_w = state_q == kfc_pkg::KFC_ST_EXEC;
    wire is_lcd_w = cmd_q == `KFC_CMD_LCD;
    wire is_keycfg_w = cmd_q == `KFC_CMD_KEYCFG;
    wire is_poll_w = cmd_q == `KFC_CMD_POLL;
    wire is_fs_w = cmd_q == `KFC_CMD_FAILSAFE;
    wire is_glitch_w = cmd_q == `KFC_CMD_GLITCH;
    wire known_w = is_lcd_w || is_keycfg_w || is_poll_w || is_fs_w || is_glitch_w;
    wire keycfg_ok_w = is_keycfg_w && len_q == `KFC_LEN_KEYCFG;
    wire poll_ok_w = is_poll_w && len_q == `KFC_LEN_POLL;
    wire fs_ok_w = is_fs_w && len_q == `KFC_LEN_FAILSAFE && buf_q[0] <= `KFC_FAN_MASK_MAX;
    wire glitch_ok_w = is_glitch_w && len_q == `KFC_LEN_GLITCH;
    wire good_w = is_lcd_w || keycfg_ok_w || poll_ok_w || fs_ok_w || glitch_ok_w;
    wire [7:0] ack_type_w = cmd_q | `KFC_REPLY_FLAG;
    wire [7:0] err_type_w = cmd_q | `KFC_ERROR_FLAG;
    wire [7:0] reply_len_w = poll_ok_w ? `KFC_LEN_POLL_REPLY : `KFC_LEN_ACK;
    wire poll_clear_w = exec_w && poll_ok_w;
    wire fs_cmd_w = exec_w && fs_ok_w;

    // Fail-safe timebase and expiry
    wire fs_tick_w = fs_div_q == FS_TICK_CYCLES[22:0] - 23'h1;
    wire fs_expire_w = fs_tick_w && fs_count_q == 8'h01 && !fan_power_write && !fs_cmd_w;
    wire fs_reload_w = fs_cmd_w || fan_power_write;
    wire [7:0] fs_load_w = fs_cmd_w ? buf_q[1] : fs_timeout_q;

    // PWM step: 100 steps of one glitch count make one PWM period
    wire step_w = step_div_q == GLITCH_CYCLES[14:0] - 15'h1;
    wire phase_wrap_w = phase_q == `KFC_PWM_STEPS - 7'h01;

    assign power_w[0] = fan1_power;
    assign power_w[1] = fan2_power;
    assign power_w[2] = fan3_power;
    assign glitch_pack_w = {glitch_q[3], glitch_q[2], glitch_q[1], glitch_q[0]};

    always_comb
    begin
        state_d = state_q;
        if (start_w)
            state_d = rx_eop ? kfc_pkg::KFC_ST_EXEC : kfc_pkg::KFC_ST_BODY;
        else
        begin
            case (state_q)
                kfc_pkg::KFC_ST_IDLE: state_d = kfc_pkg::KFC_ST_IDLE;
                kfc_pkg::KFC_ST_BODY:
                    if (body_byte_w && rx_eop)
                        state_d = kfc_pkg::KFC_ST_EXEC;
                kfc_pkg::KFC_ST_EXEC: state_d = kfc_pkg::KFC_ST_IDLE;
                default: state_d = kfc_pkg::KFC_ST_IDLE;
            endcase
        end
    end

    // Parser registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_q <= kfc_pkg::KFC_ST_IDLE;
            cmd_q <= 8'h00;
            len_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            if (start_w)
                cmd_q <= rx_data;
            if (start_w)
                len_q <= 8'h00;
            else if (body_byte_w && len_q != 8'hff)
                len_q <= len_q + 8'h01;
        end
    end

    // Payload bytes and per-fan glitch delays
    genvar gi;
    generate
        for (gi = 0; gi < `KFC_FAN_CHANNELS; gi++)
        begin : g_slot
            always_ff @(posedge clk)
            begin
                if (!nrst)
                begin
                    buf_q[gi] <= 8'h00;
                    glitch_q[gi] <= `KFC_GLITCH_RST;
                end
                else
                begin
                    if (body_byte_w && len_q == 8'(gi))
                        buf_q[gi] <= rx_data;
                    // Fourth slot is stored but drives no fan
                    if (exec_w && glitch_ok_w)
                        glitch_q[gi] <= buf_q[gi];
                end
            end
        end
    endgenerate

    // Reply and display forwarding
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_valid_q <= 1'b0;
            tx_type_q <= 8'h00;
            tx_len_q <= 8'h00;
            tx_d0_q <= 8'h00;
            tx_d1_q <= 8'h00;
            tx_d2_q <= 8'h00;
            lcd_valid_q <= 1'b0;
            lcd_data_q <= 8'h00;
        end
        else
        begin
            lcd_valid_q <= body_byte_w && is_lcd_w;
            lcd_data_q <= rx_data;
            tx_valid_q <= exec_w && known_w;
            if (exec_w && known_w)
            begin
                tx_type_q <= good_w ? ack_type_w : err_type_w;
                tx_len_q <= reply_len_w;
                // Poll reads raw key state, not the report masks
                tx_d0_q <= poll_ok_w ? {2'h0, held_w} : 8'h00;
                tx_d1_q <= poll_ok_w ? {2'h0, pressed_w} : 8'h00;
                tx_d2_q <= poll_ok_w ? {2'h0, released_w} : 8'h00;
            end
        end
    end

    // Key reporting masks and event reports
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            press_mask_q <= `KFC_KEY_MASK_RST;
            release_mask_q <= `KFC_KEY_MASK_RST;
            evt_press_q <= 6'h00;
            evt_release_q <= 6'h00;
        end
        else
        begin
            if (exec_w && keycfg_ok_w)
            begin
                press_mask_q <= buf_q[0];
                release_mask_q <= buf_q[1];
            end
            evt_press_q <= rise_w & press_mask_q[5:0];
            evt_release_q <= fall_w & release_mask_q[5:0];
        end
    end

    // Fail-safe timer
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            fs_div_q <= 23'h0;
            fs_mask_q <= 4'h0;
            fs_timeout_q <= 8'h00;
            fs_count_q <= 8'h00;
            fs_tripped_q <= 1'b0;
        end
        else
        begin
            fs_div_q <= fs_tick_w ? 23'h0 : fs_div_q + 23'h1;
            if (fs_cmd_w)
            begin
                fs_mask_q <= buf_q[0][3:0];
                fs_timeout_q <= buf_q[1];
            end
            if (fs_reload_w)
                fs_count_q <= fs_load_w;
            else if (fs_tick_w && fs_count_q != 8'h00)
                fs_count_q <= fs_count_q - 8'h01;
            if (fs_expire_w)
                fs_tripped_q <= 1'b1;
            else if (fs_reload_w)
                fs_tripped_q <= 1'b0;
        end
    end

    // PWM timebase and boot-state capture
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            step_div_q <= 15'h0;
            phase_q <= 7'h00;
            boot_press_mask_q <= `KFC_KEY_MASK_RST;
            boot_release_mask_q <= `KFC_KEY_MASK_RST;
            boot_glitch_q <= {4{`KFC_GLITCH_RST}};
        end
        else
        begin
            step_div_q <= step_w ? 15'h0 : step_div_q + 15'h1;
            if (step_w)
                phase_q <= phase_wrap_w ? 7'h00 : phase_q + 7'h01;
            if (store_boot)
            begin
                boot_press_mask_q <= press_mask_q;
                boot_release_mask_q <= release_mask_q;
                boot_glitch_q <= glitch_pack_w;
            end
        end
    end

    kfc_key_tracker u_keys (
        .clk(clk),
        .nrst(nrst),
        .key_n(key_n),
        .poll_clear(poll_clear_w),
        .held_q(held_w),
        .pressed_q(pressed_w),
        .released_q(released_w),
        .rise_q(rise_w),
        .fall_q(fall_w)
    );

    // Only the first three fans are wired on this variant
    generate
        for (gi = 0; gi < `KFC_FAN_DRIVEN; gi++)
        begin : g_fan
            kfc_fan_channel u_fan (
                .clk(clk),
                .nrst(nrst),
                .step(step_w),
                .phase(phase_q),
                .power(power_w[gi]),
                .force_full(fs_tripped_q && fs_mask_q[gi]),
                .delay(glitch_q[gi]),
                .tach(fan_tach[gi]),
                .pwm_q(fan_pwm_q[gi]),
                .tach_edge_q(tach_edge_q[gi])
            );
        end
    endgenerate

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_lcd_forward: assert property (body_byte_w && is_lcd_w
        |=> lcd_valid_q && lcd_data_q == $past(rx_data))
        else $error("display byte not forwarded");
    a_ack_type: assert property (exec_w && good_w
        |=> tx_valid_q && tx_type_q == ($past(cmd_q) | 8'h40))
        else $error("acknowledgement type wrong");
    a_poll_reply: assert property (exec_w && poll_ok_w
        |=> tx_len_q == 8'h03 && tx_d0_q[5:0] == $past(held_w))
        else $error("poll reply wrong");
    a_poll_masks: assert property (exec_w && poll_ok_w && press_mask_q == 8'h00
        |=> tx_d1_q[5:0] == $past(pressed_w))
        else $error("poll depends on report mask");
    a_event_gate: assert property (rise_w[0] |=> evt_press_q[0] == $past(press_mask_q[0]))
        else $error("press report not gated by mask");
    a_fs_invalid: assert property (exec_w && is_fs_w && buf_q[0] > 8'h0f
        |=> tx_type_q == ($past(cmd_q) | 8'h80) && $stable(fs_mask_q))
        else $error("invalid fan mask accepted");
    a_fs_expire: assert property (fs_expire_w |=> fs_tripped_q ##1 fan_pwm_q[0] || !fs_mask_q[0])
        else $error("fail-safe did not force fans");
    a_glitch_store: assert property (exec_w && glitch_ok_w
        |=> glitch_q[1] == $past(buf_q[1]) && tx_len_q == 8'h00)
        else $error("glitch delay not stored");
    a_boot_capture: assert property (store_boot |=> boot_glitch_q == $past(glitch_pack_w))
        else $error("boot state missed glitch delays");

    c_poll: cover property (exec_w && poll_ok_w ##1 tx_valid_q);
    c_fs_trip: cover property (fs_expire_w);
    c_lcd: cover property (body_byte_w && is_lcd_w ##1 lcd_valid_q);
    c_glitch: cover property (exec_w && glitch_ok_w);

endmodule // kfc_cmd_handler

// ===== verif/kfc_host_model.sv
// Host side of the packet link: sends framed command packets to the handler.
// Assumes the handler takes one byte per rising edge while rx_valid is high.
`timescale 1ns/1ns
module kfc_host_model (
    // Clock
    input wire logic clk,
    // Packet bytes towards the handler
    output logic rx_valid,
    output logic rx_sop,
    output logic rx_eop,
    output logic [7:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_sop = 1'b0;
        rx_eop = 1'b0;
        rx_data = 8'h00;
    end
    // Type byte first, then n payload bytes from p, lowest byte first
    task automatic send(input logic [7:0] t, input int n, input logic [31:0] p);
        for (int i = 0; i <= n; i++)
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_sop <= (i == 0);
            rx_eop <= (i == n);
            rx_data <= (i == 0) ? t : p[7:0];
            if (i > 0)
                p = p >> 8;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_sop <= 1'b0;
        rx_eop <= 1'b0;
        // Idle byte lane must not keep showing the last byte
        rx_data <= ~rx_data;
    endtask
endmodule // kfc_host_model

// ===== verif/tb.sv
// Self-checking bench for the keypad and fan command handler.
// Assumes short fail-safe and glitch counts set by parameter.
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rx_valid, rx_sop, rx_eop;
    logic [7:0] rx_data;
    logic tx_valid_q, lcd_valid_q, fs_tripped_q;
    logic [7:0] tx_type_q, tx_len_q, tx_d0_q, tx_d1_q, tx_d2_q, lcd_data_q;
    logic [5:0] key_n = 6'h3f;
    logic [5:0] evt_press_q, evt_release_q;
    logic [5:0] evt_seen = 6'h00;
    logic [5:0] rel_seen = 6'h00;
    logic [2:0] tach = 3'h0;
    logic [2:0] tach_seen = 3'h0;
    int cyc = 0;
    logic [7:0] p1 = 8'h00;
    logic fpw = 1'b0;
    logic sb = 1'b0;
    logic [2:0] fan_pwm_q, tach_edge_q;
    logic [3:0] fs_mask_q;
    logic [7:0] bpm, brm;
    logic [31:0] bgl;
    logic [7:0] lcd_q[$];
    int num_errors = 0;
    int checks = 0;
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        // Outputs are unknown until the first reset edge
        if (nrst)
        begin
            evt_seen <= evt_seen | evt_press_q;
            rel_seen <= rel_seen | evt_release_q;
            tach_seen <= tach_seen | tach_edge_q;
        end
        if (lcd_valid_q === 1'b1)
            lcd_q.push_back(lcd_data_q);
    end
    kfc_host_model host (.clk(clk), .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_data(rx_data));
    kfc_cmd_handler #(.FS_TICK_CYCLES(20), .GLITCH_CYCLES(4)) dut (
        .clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_data(rx_data), .tx_valid_q(tx_valid_q),
        .tx_type_q(tx_type_q), .tx_len_q(tx_len_q), .tx_d0_q(tx_d0_q),
        .tx_d1_q(tx_d1_q), .tx_d2_q(tx_d2_q), .lcd_valid_q(lcd_valid_q),
        .lcd_data_q(lcd_data_q), .key_n(key_n), .evt_press_q(evt_press_q),
        .evt_release_q(evt_release_q), .fan1_power(p1), .fan2_power(p1),
        .fan3_power(p1), .fan_power_write(fpw), .fan_tach(tach),
        .fan_pwm_q(fan_pwm_q), .tach_edge_q(tach_edge_q), .fs_mask_q(fs_mask_q),
        .fs_tripped_q(fs_tripped_q), .store_boot(sb),
        .boot_press_mask_q(bpm), .boot_release_mask_q(brm),
        .boot_glitch_q(bgl));
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Waits a bounded time for one reply pulse and checks type and length
    task automatic rsp(input logic [7:0] t, input logic [7:0] l);
        int k;
        for (k = 0; k < 10; k++)
        begin
            @(posedge clk);
            #1;
            if (tx_valid_q === 1'b1)
                break;
        end
        chk("tx_valid", 1, (k < 10));
        chk("tx_type", t, tx_type_q);
        chk("tx_len", l, tx_len_q);
    endtask
    task automatic keys(input logic [5:0] k);
        @(posedge clk);
        key_n <= ~k;
        repeat (8) @(posedge clk);
    endtask
    task automatic store();
        @(posedge clk);
        sb <= 1'b1;
        @(posedge clk);
        sb <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Waits a bounded time for the first fan's PWM to step from low to high
    task automatic pwm_rise(output int c);
        logic was;
        was = 1'b1;
        c = -1;
        for (int k = 0; k < 500; k++)
        begin
            @(posedge clk);
            #1;
            if (!was && fan_pwm_q[0] === 1'b1)
            begin
                c = cyc;
                break;
            end
            was = fan_pwm_q[0];
        end
        chk("pwm_rise", 1, (c >= 0));
    endtask
    task automatic t_lcd();
        host.send(8'h16, 2, 32'h0000_a55a);
        rsp(8'h56, 8'h00);
        chk("lcd_count", 2, lcd_q.size());
        chk("lcd_bytes", 16'h5aa5, {lcd_q[0], lcd_q[1]});
        $display("test lcd done");
    endtask
    task automatic t_keycfg();
        keys(6'h02);
        keys(6'h00);
        chk("evt_default", 6'h02, evt_seen);
        chk("rel_default", 6'h02, rel_seen);
        // Press reports off, release reports only for the left key
        host.send(8'h17, 2, 32'h0000_0800);
        rsp(8'h57, 8'h00);
        keys(6'h0c);
        keys(6'h00);
        chk("evt_masked", 6'h02, evt_seen);
        chk("rel_masked", 6'h0a, rel_seen);
        store();
        chk("boot_press", 8'h00, bpm);
        chk("boot_release", 8'h08, brm);
        $display("test keycfg done");
    endtask
    task automatic poll(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
        host.send(8'h18, 0, 32'h0);
        rsp(8'h58, 8'h03);
        chk("held", e0, tx_d0_q);
        chk("pressed", e1, tx_d1_q);
        chk("released", e2, tx_d2_q);
    endtask
    task automatic t_poll();
        poll(8'h00, 8'h0e, 8'h0e);
        keys(6'h11);
        poll(8'h11, 8'h11, 8'h00);
        keys(6'h01);
        poll(8'h01, 8'h00, 8'h10);
        keys(6'h00);
        $display("test poll done");
    endtask
    task automatic t_failsafe();
        host.send(8'h19, 2, 32'h0210);
        rsp(8'h99, 8'h00);
        chk("fs_mask_bad", 4'h0, fs_mask_q);
        host.send(8'h19, 2, 32'h020f);
        rsp(8'h59, 8'h00);
        chk("fs_mask", 4'hf, fs_mask_q);
        // Two ticks of 20 cycles: expiry lands 21 to 40 edges after the load
        repeat (20) @(posedge clk);
        #1;
        chk("early_trip", 0, fs_tripped_q);
        chk("early_pwm", 3'h0, fan_pwm_q);
        repeat (22) @(posedge clk);
        #1;
        chk("tripped", 1, fs_tripped_q);
        chk("full_pwm", 3'h7, fan_pwm_q);
        @(posedge clk);
        fpw <= 1'b1;
        @(posedge clk);
        fpw <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("trip_clear", 0, fs_tripped_q);
        chk("pwm_release", 3'h0, fan_pwm_q);
        $display("test failsafe done");
    endtask
    task automatic t_glitch();
        host.send(8'h1a, 4, 32'h0807_0605);
        rsp(8'h5a, 8'h00);
        chk("boot_before", 32'h0101_0101, bgl);
        store();
        chk("boot_glitch", 32'h0807_0605, bgl);
        $display("test glitch done");
    endtask
    // Half power; glitch delays are 5, 6 and 7 counts of 4 cycles here
    task automatic t_tach();
        int c1;
        int c2;
        @(posedge clk);
        p1 <= 8'h32;
        host.send(8'h19, 2, 32'h0);
        rsp(8'h59, 8'h00);
        chk("trip_cmd_clear", 0, fs_tripped_q);
        pwm_rise(c1);
        @(posedge clk);
        tach <= 3'h7;
        repeat (10) @(posedge clk);
        #1;
        chk("tach_blank", 3'h0, tach_seen);
        repeat (30) @(posedge clk);
        tach <= 3'h0;
        repeat (6) @(posedge clk);
        #1;
        chk("tach_pass", 3'h7, tach_seen);
        pwm_rise(c2);
        // One PWM period is 100 glitch counts of 4 cycles
        chk("pwm_period", 32'h190, c2 - c1);
        $display("test tach done");
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_glitch", 32'h0101_0101, bgl);
        chk("rst_press", 8'h3f, bpm);
        t_lcd();
        t_keycfg();
        t_poll();
        t_failsafe();
        t_glitch();
        t_tach();
        summarize();
    end
    initial
    begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule // tb
